// ===== clu_cfg.svh
// Constants of the character display command unit
`ifndef CLU_CFG_SVH
`define CLU_CFG_SVH

// Clock and oscillator
`define CLU_CLK_HZ 50000000
`define CLU_CLK_NS 20
`define CLU_OSC_HZ 250000
`define CLU_OSC_DIV (`CLU_CLK_HZ / `CLU_OSC_HZ)

// Execution times in microseconds and in clock cycles
`define CLU_INSTR_US 40
`define CLU_DATA_US 46
`define CLU_INSTR_CYC ((`CLU_INSTR_US * 1000) / `CLU_CLK_NS)
`define CLU_DATA_CYC ((`CLU_DATA_US * 1000) / `CLU_CLK_NS)

// Row length in oscillator periods and duty row counts
`define CLU_ROW_OSC_1L 400
`define CLU_ROW_OSC_2L 200
`define CLU_DUTY_1L_7 8
`define CLU_DUTY_1L_10 11
`define CLU_DUTY_2L 16

// Register byte offsets
`define CLU_OFS_INSTR 8'h00
`define CLU_OFS_DATA 8'h04
`define CLU_OFS_CFG 8'h08

// Instruction opcode bits
`define CLU_IB_CADDR 7
`define CLU_IB_GADDR 6
`define CLU_IB_FUNC 5
`define CLU_IB_SHIFT 4
`define CLU_IB_DISP 3
`define CLU_IB_ENTRY 2

// Instruction field bits
`define CLU_FB_WIDTH 4
`define CLU_FB_LINES 3
`define CLU_FB_FONT 2
`define CLU_FB_INC 1
`define CLU_FB_SHIFT 0
`define CLU_FB_SC 3
`define CLU_FB_RL 2
`define CLU_FB_DON 2
`define CLU_FB_CUR 1
`define CLU_FB_BLK 0

// Configuration register field positions
`define CLU_CR_ROW_LSB 8
`define CLU_CR_DUTY_LSB 16
`define CLU_CR_OFS_LSB 24

// Reset value of the mode byte: 8-bit bus, increment, rest clear
`define CLU_CFG_RST 8'h90

`endif

// ===== clu_pkg.sv
// Types of the character display command unit
package clu_pkg;

  typedef enum logic [1:0] {
    CLU_SEL_INSTR = 2'b00,
    CLU_SEL_DATA = 2'b01,
    CLU_SEL_CFG = 2'b10,
    CLU_SEL_NONE = 2'b11
  } clu_sel_t;

  typedef enum logic [2:0] {
    CLU_OP_NONE = 3'b000,
    CLU_OP_ENTRY = 3'b001,
    CLU_OP_DISP = 3'b010,
    CLU_OP_SHIFT = 3'b011,
    CLU_OP_FUNC = 3'b100,
    CLU_OP_GADDR = 3'b101,
    CLU_OP_CADDR = 3'b110
  } clu_op_t;

  typedef enum logic {
    CLU_ST_IDLE = 1'b0,
    CLU_ST_BUSY = 1'b1
  } clu_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    clu_sel_t sel;
  } clu_dphase_t;

  typedef struct packed {
    logic bus8;
    logic lines2;
    logic font10;
    logic inc;
    logic shift;
    logic disp_on;
    logic cursor;
    logic blink;
  } clu_cfg_t;

endpackage

// ===== clu_core.sv
// Command unit of a character display controller with AHB-Lite access
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "clu_cfg.svh"

// What this block does
// - Line-count bit picks one or two lines
// - Duty from lines and font: 8, 11, 16
// - Glyph address load selects glyph RAM
// - Character address load selects character RAM
// - Status read returns busy and pointer
// - Last set-address picks pointer's RAM
// - Data write stores byte at pointer
// - Pointer steps after every data write
// - Character write scrolls display when shift enabled
// - First read without address may be invalid
// - Read right after write returns stale
// - Cursor shift acts as character address
// - Pointer steps after every data read
// - Row 400 or 200 periods, frame rows
// - Busy blocks all but status and config reads
// - Four-bit bus moves high nibble first
// - Step direction: set up, clear down
module clu_core
  import clu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Display timing
  output logic row_pulse,
  output logic frame_pulse,
  output logic [3:0] row_index
);

  function automatic clu_sel_t clu_decode_addr(input logic [31:0] a);
    clu_sel_t s;
    s = CLU_SEL_NONE;
    if (a[31:8] == 24'h000000) begin
      if (a[7:0] == `CLU_OFS_INSTR) s = CLU_SEL_INSTR;
      else if (a[7:0] == `CLU_OFS_DATA) s = CLU_SEL_DATA;
      else if (a[7:0] == `CLU_OFS_CFG) s = CLU_SEL_CFG;
    end
    return s;
  endfunction

  function automatic clu_op_t clu_decode_op(input logic [7:0] b);
    clu_op_t o;
    o = CLU_OP_NONE;
    if (b[`CLU_IB_CADDR]) o = CLU_OP_CADDR;
    else if (b[`CLU_IB_GADDR]) o = CLU_OP_GADDR;
    else if (b[`CLU_IB_FUNC]) o = CLU_OP_FUNC;
    else if (b[`CLU_IB_SHIFT]) o = CLU_OP_SHIFT;
    else if (b[`CLU_IB_DISP]) o = CLU_OP_DISP;
    else if (b[`CLU_IB_ENTRY]) o = CLU_OP_ENTRY;
    return o;
  endfunction

  // Pointer step; glyph addresses wrap in six bits
  function automatic logic [6:0] clu_step(input logic [6:0] p,
                                          input logic up,
                                          input logic g);
    logic [6:0] n;
    n = up ? p + 7'h01 : p - 7'h01;
    if (g) n[6] = 1'b0;
    return n;
  endfunction

  function automatic logic [4:0] clu_duty(input clu_cfg_t c);
    logic [4:0] d;
    if (c.lines2) d = 5'(`CLU_DUTY_2L);
    else if (c.font10) d = 5'(`CLU_DUTY_1L_10);
    else d = 5'(`CLU_DUTY_1L_7);
    return d;
  endfunction

  clu_dphase_t dph_q;
  clu_cfg_t cfg_q;
  clu_state_t state_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic nib_lo_q;
  logic [3:0] nib_hi_q;
  logic [11:0] exec_cnt_q;
  logic [6:0] address_pointer_q;
  logic glyph_sel_q;
  logic reload_q;
  logic [7:0] latch_q;
  logic [6:0] disp_ofs_q;
  logic [7:0] glyph_ram [64];
  logic [7:0] character_code_ram [128];
  logic [7:0] osc_cnt_q;
  logic [8:0] row_cnt_q;
  logic [3:0] row_idx_q;
  logic row_pulse_q;
  logic frame_pulse_q;

  logic acc;
  logic cmd_busy_indicator;
  logic rd_ev;
  logic wr_ev;
  logic wr_go;
  logic wr_full;
  logic rd_data_go;
  logic rd_full;
  logic rd_stat;
  logic nib_tog;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  clu_op_t op;
  logic instr_full;
  logic data_wr_full;
  logic [4:0] duty;
  logic [8:0] row_len;
  logic [31:0] cfg_word;

  assign acc = hsel & htrans[1] & hready;
  assign cmd_busy_indicator = (state_q == CLU_ST_BUSY);
  assign rd_ev = dph_q.valid & ~dph_q.write & ~hready_q;
  assign wr_ev = dph_q.valid & dph_q.write & hready_q;
  assign wr_go = wr_ev & ~cmd_busy_indicator &
                 (dph_q.sel == CLU_SEL_INSTR || dph_q.sel == CLU_SEL_DATA);
  assign rd_data_go = rd_ev & ~cmd_busy_indicator &
                      (dph_q.sel == CLU_SEL_DATA);
  assign rd_stat = rd_ev & (dph_q.sel == CLU_SEL_INSTR);
  // byte completes on the low nibble
  assign wr_full = wr_go & (cfg_q.bus8 | nib_lo_q);
  assign rd_full = rd_data_go & (cfg_q.bus8 | nib_lo_q);
  assign nib_tog = ~cfg_q.bus8 & (wr_go | rd_stat | rd_data_go);
  assign wr_byte = cfg_q.bus8 ? hwdata[7:0] : {nib_hi_q, hwdata[7:4]};
  assign instr_full = wr_full & (dph_q.sel == CLU_SEL_INSTR);
  assign data_wr_full = wr_full & (dph_q.sel == CLU_SEL_DATA);
  assign op = clu_decode_op(wr_byte);
  assign duty = clu_duty(cfg_q);
  assign row_len = cfg_q.lines2 ? 9'(`CLU_ROW_OSC_2L) : 9'(`CLU_ROW_OSC_1L);
  assign cfg_word = {1'b0, disp_ofs_q, 3'b000, duty, 4'h0, row_idx_q, cfg_q};
  // status byte is busy plus pointer
  assign rd_byte = (dph_q.sel == CLU_SEL_INSTR) ?
                   {cmd_busy_indicator, address_pointer_q} : latch_q;

  // Bus slave: writes zero wait, reads one wait state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dph_q <= '{valid: 1'b0, write: 1'b0, sel: CLU_SEL_NONE};
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
    end else begin
      if (hready) begin
        dph_q <= '{valid: acc, write: hwrite, sel: clu_decode_addr(haddr)};
      end
      hready_q <= ~(acc & ~hwrite);
      if (rd_ev) begin
        if (dph_q.sel == CLU_SEL_CFG) hrdata_q <= cfg_word;
        else if (dph_q.sel == CLU_SEL_NONE) hrdata_q <= 32'h00000000;
        else if (cfg_q.bus8) hrdata_q <= {24'h000000, rd_byte};
        else if (nib_lo_q) hrdata_q <= {24'h000000, rd_byte[3:0], 4'h0};
        else hrdata_q <= {24'h000000, rd_byte[7:4], 4'h0};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nib_lo_q <= 1'b0;
      nib_hi_q <= 4'h0;
    end else begin
      if (cfg_q.bus8) nib_lo_q <= 1'b0;
      else if (nib_tog) nib_lo_q <= ~nib_lo_q;
      if (wr_go & ~cfg_q.bus8 & ~nib_lo_q) nib_hi_q <= hwdata[7:4];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= CLU_ST_IDLE;
      exec_cnt_q <= 12'h000;
    end else begin
      unique case (state_q)
        CLU_ST_IDLE: begin
          if (instr_full) begin
            state_q <= CLU_ST_BUSY;
            exec_cnt_q <= 12'(`CLU_INSTR_CYC - 1);
          end else if (data_wr_full | rd_full) begin
            state_q <= CLU_ST_BUSY;
            exec_cnt_q <= 12'(`CLU_DATA_CYC - 1);
          end
        end
        CLU_ST_BUSY: begin
          if (exec_cnt_q == 12'h000) state_q <= CLU_ST_IDLE;
          else exec_cnt_q <= exec_cnt_q - 12'h001;
        end
      endcase
    end
  end

  // Mode settings
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_q <= `CLU_CFG_RST;
    end else if (instr_full) begin
      if (op == CLU_OP_FUNC) begin
        cfg_q.bus8 <= wr_byte[`CLU_FB_WIDTH];
        cfg_q.lines2 <= wr_byte[`CLU_FB_LINES];
        cfg_q.font10 <= wr_byte[`CLU_FB_FONT];
      end
      if (op == CLU_OP_ENTRY) begin
        cfg_q.inc <= wr_byte[`CLU_FB_INC];
        cfg_q.shift <= wr_byte[`CLU_FB_SHIFT];
      end
      if (op == CLU_OP_DISP) begin
        cfg_q.disp_on <= wr_byte[`CLU_FB_DON];
        cfg_q.cursor <= wr_byte[`CLU_FB_CUR];
        cfg_q.blink <= wr_byte[`CLU_FB_BLK];
      end
    end
  end

  // Address pointer and RAM target
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      address_pointer_q <= 7'h00;
      glyph_sel_q <= 1'b0;
      reload_q <= 1'b0;
    end else begin
      reload_q <= 1'b0;
      if (instr_full) begin
        unique case (op)
          CLU_OP_CADDR: begin
            address_pointer_q <= wr_byte[6:0];
            glyph_sel_q <= 1'b0;
            reload_q <= 1'b1;
          end
          CLU_OP_GADDR: begin
            address_pointer_q <= {1'b0, wr_byte[5:0]};
            glyph_sel_q <= 1'b1;
            reload_q <= 1'b1;
          end
          CLU_OP_SHIFT: begin
            if (!wr_byte[`CLU_FB_SC]) begin
              address_pointer_q <= clu_step(address_pointer_q,
                                            wr_byte[`CLU_FB_RL], 1'b0);
              glyph_sel_q <= 1'b0;
              reload_q <= 1'b1;
            end
          end
          CLU_OP_NONE, CLU_OP_ENTRY, CLU_OP_DISP, CLU_OP_FUNC: begin
          end
        endcase
      end else if (data_wr_full) begin
        address_pointer_q <= clu_step(address_pointer_q, cfg_q.inc,
                                      glyph_sel_q);
      end else if (rd_full) begin
        address_pointer_q <= clu_step(address_pointer_q, cfg_q.inc,
                                      glyph_sel_q);
        reload_q <= 1'b1;
      end
    end
  end

  // latch keeps its reset value until a reload
  // read latch is refreshed only by reload
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      latch_q <= 8'h00;
    end else if (reload_q) begin
      latch_q <= glyph_sel_q ? glyph_ram[address_pointer_q[5:0]] :
                 character_code_ram[address_pointer_q];
    end
  end

  // store byte in the selected RAM
  always_ff @(posedge ref_clk) begin
    if (data_wr_full) begin
      if (glyph_sel_q) glyph_ram[address_pointer_q[5:0]] <= wr_byte;
      else character_code_ram[address_pointer_q] <= wr_byte;
    end
  end

  // display scroll on write or shift
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      disp_ofs_q <= 7'h00;
    end else if (data_wr_full & cfg_q.shift & ~glyph_sel_q) begin
      disp_ofs_q <= cfg_q.inc ? disp_ofs_q + 7'h01 : disp_ofs_q - 7'h01;
    end else if (instr_full & (op == CLU_OP_SHIFT) &
                 wr_byte[`CLU_FB_SC]) begin
      disp_ofs_q <= wr_byte[`CLU_FB_RL] ? disp_ofs_q - 7'h01 :
                    disp_ofs_q + 7'h01;
    end
  end

  // oscillator enable, row and frame timing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      osc_cnt_q <= 8'h00;
      row_cnt_q <= 9'h000;
      row_idx_q <= 4'h0;
      row_pulse_q <= 1'b0;
      frame_pulse_q <= 1'b0;
    end else begin
      row_pulse_q <= 1'b0;
      frame_pulse_q <= 1'b0;
      if (osc_cnt_q == 8'(`CLU_OSC_DIV - 1)) begin
        osc_cnt_q <= 8'h00;
        if (row_cnt_q >= row_len - 9'h001) begin
          row_cnt_q <= 9'h000;
          row_pulse_q <= 1'b1;
          if ({1'b0, row_idx_q} >= duty - 5'h01) begin
            row_idx_q <= 4'h0;
            frame_pulse_q <= 1'b1;
          end else begin
            row_idx_q <= row_idx_q + 4'h1;
          end
        end else begin
          row_cnt_q <= row_cnt_q + 9'h001;
        end
      end else begin
        osc_cnt_q <= osc_cnt_q + 8'h01;
      end
    end
  end

  assign hreadyout = hready_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign row_pulse = row_pulse_q;
  assign frame_pulse = frame_pulse_q;
  assign row_index = row_idx_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Row gap count; zero while a line-count change leaves a row unmeasured
  logic [16:0] gap_q;
  logic [11:0] busy_len_q;
  logic busy_ins_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || (instr_full && op == CLU_OP_FUNC &&
        wr_byte[`CLU_FB_LINES] != cfg_q.lines2)) gap_q <= 17'h00000;
    else if (row_pulse_q) gap_q <= 17'h00001;
    else if (gap_q != 17'h00000) gap_q <= gap_q + 17'h00001;
  end
  // Length of the current busy stretch and what started it
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !cmd_busy_indicator) busy_len_q <= 12'h000;
    else busy_len_q <= busy_len_q + 12'h001;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) busy_ins_q <= 1'b0;
    else if (instr_full | data_wr_full | rd_full) busy_ins_q <= instr_full;
  end

  sequence s_rd_step;
    rd_full ##1 reload_q;
  endsequence

  lines_sel_a: assert property (
    instr_full && op == CLU_OP_FUNC |=>
      cfg_q.lines2 == $past(wr_byte[`CLU_FB_LINES]))
    else $error("line count not taken");
  duty_frame_a: assert property (
    $rose(frame_pulse_q) && $stable(cfg_q) |->
      $past(row_idx_q) == 4'(duty - 5'h01))
    else $error("frame length does not match duty");
  glyph_load_a: assert property (
    instr_full && op == CLU_OP_GADDR |=>
      glyph_sel_q && address_pointer_q == {1'b0, $past(wr_byte[5:0])})
    else $error("glyph address not loaded");
  char_load_a: assert property (
    instr_full && op == CLU_OP_CADDR |=>
      !glyph_sel_q && address_pointer_q == $past(wr_byte[6:0]))
    else $error("character address not loaded");
  status_read_a: assert property (
    rd_stat && cfg_q.bus8 |=>
      hrdata_q[7:0] == {$past(cmd_busy_indicator), $past(address_pointer_q)})
    else $error("status read wrong");
  ram_store_a: assert property (
    data_wr_full && !glyph_sel_q |=>
      character_code_ram[$past(address_pointer_q)] == $past(wr_byte))
    else $error("data byte not stored");
  write_step_a: assert property (
    data_wr_full |=> address_pointer_q == clu_step($past(address_pointer_q),
      $past(cfg_q.inc), $past(glyph_sel_q)))
    else $error("pointer did not step after write");
  stale_latch_a: assert property (
    data_wr_full |=> $stable(latch_q))
    else $error("latch changed on write");
  read_fetch_a: assert property (
    s_rd_step |=> latch_q == (glyph_sel_q ? glyph_ram[address_pointer_q[5:0]]
      : character_code_ram[address_pointer_q]))
    else $error("read did not refetch at stepped pointer");
  row_period_a: assert property (
    row_pulse_q && $stable(cfg_q.lines2) && gap_q > 17'h00001 |->
      gap_q == 17'(row_len) * 17'(`CLU_OSC_DIV))
    else $error("row period wrong");
  busy_hold_a: assert property (
    instr_full |=> cmd_busy_indicator [*8])
    else $error("busy not held after instruction");
  busy_len_a: assert property (
    $fell(cmd_busy_indicator) |->
      busy_len_q == (busy_ins_q ? 12'(`CLU_INSTR_CYC) : 12'(`CLU_DATA_CYC)))
    else $error("busy length wrong");
  nibble_wait_a: assert property (
    wr_go && !cfg_q.bus8 && !nib_lo_q |=> $stable(address_pointer_q)
      && !cmd_busy_indicator)
    else $error("high nibble acted alone");

endmodule // clu_core
`default_nettype wire

// ===== clu_host.sv
// Bus master model standing in for the host processor
`timescale 1ns/100ps
`default_nettype none
module clu_host (
  // Clock
  input wire logic ref_clk,
  // Slave answer
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // Master request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  int hangs = 0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Bounded wait for hready sampled at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 64) begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 64) hangs++;
  endtask
  // Single word transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'b00;
    // Unused write lines keep toggling on reads
    hwdata <= w ? d : ~hwdata;
    wait_rdy();
    r = hrdata;
  endtask
endmodule // clu_host
`default_nettype wire

// ===== clu_core_tb.sv
// Self-checking bench of the character display command unit
`timescale 1ns/100ps
`default_nettype none
`include "clu_cfg.svh"
module clu_core_tb;
  typedef struct {
    logic [7:0] ins;
    int duty;
    logic lines2;
  } clu_tb_row_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, row_pulse, frame_pulse, nib;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] row_index;
  logic [3:0] k_prev = 4'h0;
  logic [3:0] k_last = 4'h0;
  logic f_last = 1'b0;
  logic [7:0] q;
  int n;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int gap = 0;
  int pulses = 0;
  clu_tb_row_t rows [4] = '{'{8'h20, `CLU_DUTY_1L_7, 1'b0},
    '{8'h24, `CLU_DUTY_1L_10, 1'b0}, '{8'h28, `CLU_DUTY_2L, 1'b1},
    '{8'h2C, `CLU_DUTY_2L, 1'b1}};
  always #(`CLU_CLK_NS / 2) ref_clk = ~ref_clk;
  // Row pulse watch, running beside the command traffic
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cyc <= 0;
      pulses <= 0;
    end else if (row_pulse === 1'b1) begin
      gap <= cyc + 1;
      cyc <= 0;
      pulses <= pulses + 1;
      k_prev <= k_last;
      k_last <= row_index;
      f_last <= frame_pulse;
    end else begin
      cyc <= cyc + 1;
    end
  end
  clu_core uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .row_pulse(row_pulse),
    .frame_pulse(frame_pulse), .row_index(row_index));
  clu_host host (.ref_clk(ref_clk), .hreadyout(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  task automatic summarize();
    num_errors += host.hangs;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    nib = 1'b0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] o);
    logic [31:0] rr;
    if (nib) begin
      host.xfer(w, {24'h0, a}, {24'h0, d[7:4], 4'h0}, rr);
      o[7:4] = rr[7:4];
      host.xfer(w, {24'h0, a}, {24'h0, d[3:0], 4'h0}, rr);
      o[3:0] = rr[7:4];
    end else begin
      host.xfer(w, {24'h0, a}, {24'h0, d}, rr);
      o = rr[7:0];
    end
    if (host.hangs > 0) summarize();
  endtask
  task automatic poll();
    logic [7:0] s;
    int t;
    s = 8'h80;
    t = 0;
    while (s[7] !== 1'b0 && t < 3000) begin
      acc(1'b0, `CLU_OFS_INSTR, 8'h00, s);
      t++;
    end
    if (t == 3000) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    logic [7:0] o;
    poll();
    acc(1'b1, `CLU_OFS_INSTR, b, o);
  endtask
  task automatic dat(input logic [7:0] b);
    logic [7:0] o;
    poll();
    acc(1'b1, `CLU_OFS_DATA, b, o);
  endtask
  task automatic rdd(output logic [7:0] o);
    poll();
    acc(1'b0, `CLU_OFS_DATA, 8'h00, o);
  endtask
  task automatic stat(output logic [7:0] o);
    poll();
    acc(1'b0, `CLU_OFS_INSTR, 8'h00, o);
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      do_reset();
      cmd(rows[i].ins);
      host.xfer(1'b0, {24'h0, `CLU_OFS_CFG}, 32'h0, r);
      chk("lines", {31'h0, rows[i].lines2}, {31'h0, r[6]});
      chk("duty", rows[i].duty, {27'h0, r[20:16]});
    end
    do_reset();
    stat(q);
    chk("status", 8'h00, q);
    cmd(8'h30);
    cmd(8'h30);
    cmd(8'h38);
    acc(1'b0, `CLU_OFS_INSTR, 8'h00, q);
    chk("busy", 1'b1, q[7]);
    cmd(8'h0D);
    cmd(8'h01);
    cmd(8'h06);
    cmd(8'hFE);
    stat(q);
    chk("pointer", 8'h7E, q);
    dat(8'hA5);
    acc(1'b1, `CLU_OFS_DATA, 8'hFF, q);
    dat(8'h3C);
    stat(q);
    chk("pointer", 8'h00, q);
    cmd(8'hFE);
    rdd(q);
    chk("data", 8'hA5, q);
    stat(q);
    chk("pointer", 8'h7F, q);
    rdd(q);
    chk("data", 8'h3C, q);
    cmd(8'h7F);
    dat(8'h5A);
    stat(q);
    chk("pointer", 8'h00, q);
    cmd(8'h7F);
    rdd(q);
    chk("glyph", 8'h5A, q);
    cmd(8'hFF);
    rdd(q);
    chk("data", 8'h3C, q);
    cmd(8'h04);
    cmd(8'h85);
    dat(8'h11);
    stat(q);
    chk("pointer", 8'h04, q);
    dat(8'h22);
    cmd(8'h14);
    rdd(q);
    chk("data", 8'h22, q);
    stat(q);
    chk("pointer", 8'h03, q);
    cmd(8'h07);
    dat(8'h44);
    host.xfer(1'b0, {24'h0, `CLU_OFS_CFG}, 32'h0, r);
    chk("offset", 32'h1, {25'h0, r[30:24]});
    chk("display", 32'h5, {29'h0, r[2:0]});
    host.xfer(1'b0, 32'h0000000C, 32'h0, r);
    chk("unmapped", 32'h0, r);
    chk("hresp", 32'h0, {31'h0, hresp});
    cmd(8'h28);
    nib = 1'b1;
    cmd(8'h90);
    dat(8'h6C);
    cmd(8'h90);
    rdd(q);
    chk("nibbles", 8'h6C, q);
    stat(q);
    chk("pointer", 8'h11, q);
    n = 0;
    while (pulses < 2 && n < 90000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 90000) begin
      num_errors++;
      summarize();
    end
    chk("row", `CLU_ROW_OSC_2L * `CLU_OSC_DIV, gap);
    chk("index", 4'(k_prev + 4'h1), k_last);
    chk("frame", {31'h0, k_last == 4'h0}, {31'h0, f_last});
    summarize();
  end
endmodule // clu_core_tb
`default_nettype wire
